// ### hdl/pcg_pkg.sv
package pcg_pkg;

  // register byte offsets
  localparam logic [11:0] PCG_RUN_ZERO_OFF    = 12'h0100;
  localparam logic [11:0] PCG_RUN_ONE_OFF     = 12'h0104;
  localparam logic [11:0] PCG_SLEEP_ZERO_OFF  = 12'h0110;
  localparam logic [11:0] PCG_SLEEP_ONE_OFF   = 12'h0114;
  localparam logic [11:0] PCG_DEEP_ZERO_OFF   = 12'h0120;
  localparam logic [11:0] PCG_DEEP_ONE_OFF    = 12'h0124;
  localparam logic [11:0] PCG_RUN_CONFIG_OFF  = 12'h0060;
  localparam logic [11:0] PCG_INT_STATUS_OFF  = 12'h0130;
  localparam logic [11:0] PCG_INT_MASK_OFF    = 12'h0134;
  localparam logic [11:0] PCG_FAULT_ADDR_OFF  = 12'h0138;

  // writable bit masks of the two gating register layouts
  localparam logic [31:0] PCG_ZERO_MASK = 32'h0310_0048;
  localparam logic [31:0] PCG_ONE_MASK  = 32'h070F_1111;
  localparam logic [31:0] PCG_GATE_RESET = 32'h0000_0000;

  // field positions, set zero
  localparam int PCG_CAN_SECOND_BIT  = 25;
  localparam int PCG_CAN_FIRST_BIT   = 24;
  localparam int PCG_PWM_BIT         = 20;
  localparam int PCG_HIBERNATION_BIT = 6;
  localparam int PCG_WATCHDOG_BIT    = 3;
  // auto gating select position in run clock config
  localparam int PCG_AUTO_GATE_BIT  = 27;

  // unit count: 32 bits of set zero then 32 of set one
  localparam int PCG_UNITS = 64;

  // interrupt status bits
  localparam int PCG_EV_FAULT     = 0;
  localparam int PCG_EV_MODE      = 1;
  localparam int PCG_EV_WIDTH     = 2;

  // power modes
  typedef enum logic [1:0] {
    PCG_MODE_RUN,
    PCG_MODE_SLEEP,
    PCG_MODE_DEEP
  } pcg_mode_type;

endpackage

// ### hdl/pcg_mode_select.sv
`timescale 1ns/1ps
// picks which gating set applies in the present power mode
module pcg_mode_select
  import pcg_pkg::*;
(
  // mode and selector
  input  wire logic [1:0]  mode_in,
  input  wire logic        auto_gate_in,
  // the three sets, 64 unit bits each
  input  wire logic [63:0] run_set_in,
  input  wire logic [63:0] sleep_set_in,
  input  wire logic [63:0] deep_set_in,
  // chosen set
  output logic      [63:0] active_set_out
);

  // without auto gating the run set stays in force in every mode
  always_comb begin
    active_set_out = run_set_in;
    if (auto_gate_in) begin
      unique case (mode_in)
        PCG_MODE_SLEEP: active_set_out = sleep_set_in;
        PCG_MODE_DEEP:  active_set_out = deep_set_in;
        default:        active_set_out = run_set_in;
      endcase
    end
  end

endmodule

// ### hdl/pcg_gating.sv
`timescale 1ns/1ps
module pcg_gating
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  // register port
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  // processor power mode
  input  wire logic        sleep_in,
  input  wire logic        deep_sleep_in,
  // peripheral access probe: unit index and access strobe
  input  wire logic [5:0]  unit_sel_in,
  input  wire logic        unit_access_in,
  // per-unit clock enables
  output logic      [63:0] unit_clk_en_out,
  // bus fault pulse and interrupt
  output logic             bus_fault_out,
  output logic             irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // register map, byte offsets from the control base
  //   0x100  run set zero: can 25 and 24, pwm 20, hibernation 6,
  //          watchdog 3
  //   0x104  run set one: comparators, timers, serial units
  //   0x110  sleep set zero, laid out like run set zero
  //   0x114  sleep set one, laid out like run set one
  //   0x120  deep sleep set zero
  //   0x124  deep sleep set one
  //   0x060  run clock config, bit 27 selects automatic gating
  //   0x130  interrupt status, write one to clear
  //   0x134  interrupt mask, laid out like the status
  //   0x138  unit index of the most recent fault, bits 5:0
  //   other offsets ignore writes and read as zero
  // status bit 0 records a fault, bit 1 a change of power mode
  // reserved bits ignore writes and read back as zero, so a
  // read-modify-write by software leaves them as they were
  // the probe port names a unit by its bit in {set one, set zero}:
  // 0 to 31 fall in set zero, 32 to 63 in set one

  ////////////////////////////////////////////////////////////////////////
  // state
  // four groups of state below, each with one process for its next
  // values and one that only stores them
  logic [31:0] run_zero;        // run set zero
  logic [31:0] run_one;         // run set one
  logic [31:0] sleep_zero;      // sleep set zero
  logic [31:0] sleep_one;       // sleep set one
  logic [31:0] deep_zero;       // deep set zero
  logic [31:0] deep_one;        // deep set one
  logic        auto_gate;       // automatic gating select
  logic [PCG_EV_WIDTH-1:0] int_status; // sticky events
  logic [PCG_EV_WIDTH-1:0] int_mask;   // interrupt mask
  logic [5:0]  fault_unit;      // unit of the last fault
  logic [1:0]  last_mode;       // mode seen last cycle
  logic [63:0] clk_en;          // registered enables
  logic        fault;           // registered fault pulse
  logic        irq;             // registered interrupt
  logic [31:0] rdata;           // registered read data

  // next values
  logic [31:0] next_run_zero;
  logic [31:0] next_run_one;
  logic [31:0] next_sleep_zero;
  logic [31:0] next_sleep_one;
  logic [31:0] next_deep_zero;
  logic [31:0] next_deep_one;
  logic        next_auto_gate;
  logic [PCG_EV_WIDTH-1:0] next_int_status;
  logic [PCG_EV_WIDTH-1:0] next_int_mask;
  logic [5:0]  next_fault_unit;
  logic [1:0]  next_last_mode;
  logic [63:0] next_clk_en;
  logic        next_fault;
  logic        next_irq;
  logic [31:0] next_rdata;

  // combinational helpers
  pcg_mode_type mode;           // present power mode
  logic [63:0]  active_set;     // set in force this cycle
  logic [PCG_EV_WIDTH-1:0] events; // event pulses this cycle

  ////////////////////////////////////////////////////////////////////////
  // mode decode: deep sleep wins if both are asserted
  // both levels are taken as synchronous to the clock; a step from
  // sleep to deep sleep counts as one more change of mode
  always_comb begin
    if (deep_sleep_in) begin
      mode = PCG_MODE_DEEP;
    end else if (sleep_in) begin
      mode = PCG_MODE_SLEEP;
    end else begin
      mode = PCG_MODE_RUN;
    end
  end

  // set selection lives in its own module
  // a change of mode reaches the enables one cycle later, so the
  // first cycle of sleep still runs on the set that applied before
  pcg_mode_select u_select (
    .mode_in        (mode),
    .auto_gate_in   (auto_gate),
    .run_set_in     ({run_one, run_zero}),
    .sleep_set_in   ({sleep_one, sleep_zero}),
    .deep_set_in    ({deep_one, deep_zero}),
    .active_set_out (active_set)
  );

  ////////////////////////////////////////////////////////////////////////
  // gating registers and config: writes keep reserved bits at zero
  // a write lands on the edge that takes it, so a read in the very
  // next cycle already returns the new value
  always_comb begin
    next_run_zero   = run_zero;
    next_run_one    = run_one;
    next_sleep_zero = sleep_zero;
    next_sleep_one  = sleep_one;
    next_deep_zero  = deep_zero;
    next_deep_one   = deep_one;
    next_auto_gate  = auto_gate;
    next_int_mask   = int_mask;
    if (reg_write_in) begin
      unique case (reg_addr_in)
        PCG_RUN_ZERO_OFF: begin
          next_run_zero = reg_wdata_in & PCG_ZERO_MASK;
        end
        PCG_RUN_ONE_OFF: begin
          next_run_one = reg_wdata_in & PCG_ONE_MASK;
        end
        PCG_SLEEP_ZERO_OFF: begin
          next_sleep_zero = reg_wdata_in & PCG_ZERO_MASK;
        end
        PCG_SLEEP_ONE_OFF: begin
          next_sleep_one = reg_wdata_in & PCG_ONE_MASK;
        end
        PCG_DEEP_ZERO_OFF: begin
          next_deep_zero = reg_wdata_in & PCG_ZERO_MASK;
        end
        PCG_DEEP_ONE_OFF: begin
          next_deep_one = reg_wdata_in & PCG_ONE_MASK;
        end
        PCG_RUN_CONFIG_OFF: begin
          next_auto_gate = reg_wdata_in[PCG_AUTO_GATE_BIT];
        end
        PCG_INT_MASK_OFF: begin
          next_int_mask = reg_wdata_in[PCG_EV_WIDTH-1:0];
        end
        default: begin
          // other offsets are ignored on write
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault detection, fault unit, mode history and enables
  // the fault looks at the set in force now rather than at the
  // lagging enable output, so a write that switches a unit on
  // already covers an access taken in the following cycle
  always_comb begin
    // an access to a gated unit completes as a fault, not a transfer
    next_fault      = unit_access_in && !active_set[unit_sel_in];
    next_fault_unit = next_fault ? unit_sel_in : fault_unit;
    next_last_mode  = mode;
    next_clk_en     = active_set;
    events[PCG_EV_FAULT] = next_fault;
    events[PCG_EV_MODE]  = (mode != pcg_mode_type'(last_mode));
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status and level
  always_comb begin
    next_int_status = int_status;
    if (reg_write_in && reg_addr_in == PCG_INT_STATUS_OFF) begin
      // write one to clear; zero bits leave their status alone
      next_int_status = int_status & ~reg_wdata_in[PCG_EV_WIDTH-1:0];
    end
    // a new event wins over a clear in the same cycle, so an event
    // that lands beside the clear is never lost
    next_int_status = next_int_status | events;
    // mask is the registered value: a mask write shows a cycle later
    next_irq        = |(next_int_status & int_mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux: data appear the cycle after the read strobe
  // reads have no side effect: status bits clear only on a write,
  // so a polling loop cannot lose an event
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_read_in) begin
      unique case (reg_addr_in)
        PCG_RUN_ZERO_OFF:   next_rdata = run_zero;
        PCG_RUN_ONE_OFF:    next_rdata = run_one;
        PCG_SLEEP_ZERO_OFF: next_rdata = sleep_zero;
        PCG_SLEEP_ONE_OFF:  next_rdata = sleep_one;
        PCG_DEEP_ZERO_OFF:  next_rdata = deep_zero;
        PCG_DEEP_ONE_OFF:   next_rdata = deep_one;
        PCG_RUN_CONFIG_OFF: next_rdata[PCG_AUTO_GATE_BIT] = auto_gate;
        PCG_INT_STATUS_OFF: next_rdata[PCG_EV_WIDTH-1:0] = int_status;
        PCG_INT_MASK_OFF:   next_rdata[PCG_EV_WIDTH-1:0] = int_mask;
        PCG_FAULT_ADDR_OFF: next_rdata[5:0] = fault_unit;
        default:            next_rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers: every gating bit clears at reset, so all
  // units start unclocked and software turns on only what it needs;
  // the mask and the auto select clear with them
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      run_zero   <= PCG_GATE_RESET;
      run_one    <= PCG_GATE_RESET;
      sleep_zero <= PCG_GATE_RESET;
      sleep_one  <= PCG_GATE_RESET;
      deep_zero  <= PCG_GATE_RESET;
      deep_one   <= PCG_GATE_RESET;
      auto_gate  <= 1'b0;
      int_mask   <= '0;
    end else begin
      run_zero   <= next_run_zero;
      run_one    <= next_run_one;
      sleep_zero <= next_sleep_zero;
      sleep_one  <= next_sleep_one;
      deep_zero  <= next_deep_zero;
      deep_one   <= next_deep_one;
      auto_gate  <= next_auto_gate;
      int_mask   <= next_int_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault pulse, fault unit, mode history and registered enables;
  // the enables trail the gating registers by one cycle
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fault_unit <= 6'h00;
      last_mode  <= 2'h0;
      clk_en     <= 64'h0000_0000_0000_0000;
      fault      <= 1'b0;
    end else begin
      fault_unit <= next_fault_unit;
      last_mode  <= next_last_mode;
      clk_en     <= next_clk_en;
      fault      <= next_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky event bits and the interrupt level built from them;
  // irq follows status with no further delay; a mask write reaches it one cycle later
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      int_status <= '0;
      irq        <= 1'b0;
    end else begin
      int_status <= next_int_status;
      irq        <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data register: zero in every cycle but the answer cycle
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops; bits 6, 3 and 20 gate the
  // hibernation, watchdog and pwm units, and the enables trail a
  // gating write by two edges: one into the register, one into the flop
  assign unit_clk_en_out = clk_en;
  assign bus_fault_out   = fault;
  assign irq_out         = irq;
  assign reg_rdata_out   = rdata;

endmodule

// ### tb/pcg_gating_chk.sv
`timescale 1ns/1ps
// port-level watcher of the clock gating block
module pcg_gating_chk
  import pcg_pkg::*;
(
  // clock, reset and register port
  input wire logic        mclk_in,
  input wire logic        resetn_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  // mode, access probe and results
  input wire logic        sleep_in,
  input wire logic        deep_sleep_in,
  input wire logic [5:0]  unit_sel_in,
  input wire logic        unit_access_in,
  input wire logic [63:0] unit_clk_en_out,
  input wire logic        bus_fault_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // in run mode the run set applies whatever the auto select holds
  logic run_md;
  logic mask_wr;
  assign run_md = !sleep_in && !deep_sleep_in;
  assign mask_wr = reg_write_in && reg_addr_in == PCG_INT_MASK_OFF;
  // power mode as the block decodes it, deep sleep first
  logic [1:0] md;
  assign md = deep_sleep_in ? PCG_MODE_DEEP :
              sleep_in ? PCG_MODE_SLEEP : PCG_MODE_RUN;
  //////////////////////////////////////////////////////////////////////////
  property p_fault;
    unit_access_in |=> bus_fault_out == !unit_clk_en_out[$past(unit_sel_in)];
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault does not follow unit enable");
  property p_quiet; !unit_access_in |=> !bus_fault_out; endproperty
  a_quiet: assert property (p_quiet)
    else $error("fault without access");
  property p_rst; $rose(resetn_in) |-> unit_clk_en_out == '0; endproperty
  a_rst: assert property (p_rst)
    else $error("enables not clear after reset");
  property p_resv;
    (unit_clk_en_out & ~{PCG_ONE_MASK, PCG_ZERO_MASK}) == '0;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved enable set");
  property p_idle; !reg_read_in |=> reg_rdata_out == '0; endproperty
  a_idle: assert property (p_idle)
    else $error("read data outside read answer");
  // a run set write shows on the enables two cycles on
  property p_run0;
    reg_write_in && reg_addr_in == PCG_RUN_ZERO_OFF && run_md ##1 run_md
      |=> unit_clk_en_out[31:0] == ($past(reg_wdata_in, 2) & PCG_ZERO_MASK);
  endproperty
  a_run0: assert property (p_run0)
    else $error("run set zero not applied");
  property p_run1;
    reg_write_in && reg_addr_in == PCG_RUN_ONE_OFF && run_md ##1 run_md
      |=> unit_clk_en_out[63:32] == ($past(reg_wdata_in, 2) & PCG_ONE_MASK);
  endproperty
  a_run1: assert property (p_run1)
    else $error("run set one not applied");
  // interrupt only rises with a fault, after unmasking or a mode change
  property p_irq;
    $rose(irq_out) |-> bus_fault_out || $past(mask_wr, 2) ||
      $past(md) != $past(md, 2);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without cause");
endmodule

bind pcg_gating pcg_gating_chk u_chk (.mclk_in, .resetn_in, .reg_addr_in,
  .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .sleep_in,
  .deep_sleep_in, .unit_sel_in, .unit_access_in, .unit_clk_en_out,
  .bus_fault_out, .irq_out);

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import pcg_pkg::*;
;
  // ports of the block, driven and observed
  logic        mclk_in = 1'b0, resetn_in = 1'b0, sleep_in = 1'b0;
  logic        reg_write_in = 1'b0, reg_read_in = 1'b0, deep_sleep_in = 1'b0;
  logic        unit_access_in = 1'b0, bus_fault_out, irq_out;
  logic [5:0]  unit_sel_in = '0;
  logic [11:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out;
  logic [63:0] unit_clk_en_out;
  int          error_cnt = 0, checks_done = 0;
  // gating offsets, zero layouts at even places
  localparam logic [11:0] OFFS [6] = '{PCG_RUN_ZERO_OFF, PCG_RUN_ONE_OFF,
    PCG_SLEEP_ZERO_OFF, PCG_SLEEP_ONE_OFF, PCG_DEEP_ZERO_OFF, PCG_DEEP_ONE_OFF};
  localparam int UNITS [5] = '{PCG_WATCHDOG_BIT, PCG_HIBERNATION_BIT,
    PCG_PWM_BIT, PCG_CAN_FIRST_BIT, PCG_CAN_SECOND_BIT};

  pcg_gating dut (.mclk_in, .resetn_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_read_in, .reg_rdata_out, .sleep_in, .deep_sleep_in,
    .unit_sel_in, .unit_access_in, .unit_clk_en_out, .bus_fault_out, .irq_out);
  //////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge mclk_in);
    reg_write_in <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge mclk_in);
    reg_read_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask
  // one access to a unit; the fault pulse is looked at in its one cycle
  task automatic probe(input int u, input logic exp);
    @(posedge mclk_in);
    unit_sel_in <= 6'(u);
    unit_access_in <= 1'b1;
    @(posedge mclk_in);
    unit_access_in <= 1'b0;
    #1;
    chk(bus_fault_out, exp);
  endtask
  // register then enable flop: two edges, one spare
  task automatic settle();
    repeat (3) @(posedge mclk_in);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk_in);
    resetn_in <= 1'b1;
    settle();
    chk(unit_clk_en_out, '0);
    for (int i = 0; i < 6; i++) begin
      rd(OFFS[i], '0);
      wr(OFFS[i], 32'hFFFF_FFFF);
      rd(OFFS[i], i[0] ? PCG_ONE_MASK : PCG_ZERO_MASK);
    end
    wr(12'h00FC, 32'hFFFF_FFFF);
    rd(12'h00FC, '0);
    settle();
    chk(unit_clk_en_out, {PCG_ONE_MASK, PCG_ZERO_MASK});
    for (int i = 0; i < 5; i++) probe(UNITS[i], 1'b0);
    probe(32, 1'b0);
    wr(PCG_RUN_ZERO_OFF, '0);
    wr(PCG_RUN_ONE_OFF, '0);
    settle();
    chk(unit_clk_en_out, '0);
    for (int i = 0; i < 5; i++) probe(UNITS[i], 1'b1);
    probe(32, 1'b1);
    // distinct sets per mode, auto select still off
    wr(PCG_RUN_ZERO_OFF, 32'hFFFF_FFFF);
    wr(PCG_SLEEP_ZERO_OFF, 32'h0000_0008);
    wr(PCG_DEEP_ZERO_OFF, 32'h0000_0040);
    @(posedge mclk_in);
    sleep_in <= 1'b1;
    settle();
    chk(unit_clk_en_out, {32'h0000_0000, PCG_ZERO_MASK});
    rd(PCG_INT_STATUS_OFF, 32'h0000_0003);
    wr(PCG_RUN_CONFIG_OFF, 32'h0800_0000);
    settle();
    chk(unit_clk_en_out, {PCG_ONE_MASK, 32'h0000_0008});
    @(posedge mclk_in);
    deep_sleep_in <= 1'b1;
    settle();
    chk(unit_clk_en_out, {PCG_ONE_MASK, 32'h0000_0040});
    probe(PCG_WATCHDOG_BIT, 1'b1);
    probe(PCG_HIBERNATION_BIT, 1'b0);
    @(posedge mclk_in);
    sleep_in <= 1'b0;
    deep_sleep_in <= 1'b0;
    // fault event, mask and sticky clear
    wr(PCG_RUN_ZERO_OFF, '0);
    wr(PCG_INT_STATUS_OFF, 32'h0000_0003);
    wr(PCG_INT_MASK_OFF, 32'h0000_0001);
    probe(PCG_WATCHDOG_BIT, 1'b1);
    chk(irq_out, 1'b1);
    rd(PCG_FAULT_ADDR_OFF, 32'h0000_0003);
    rd(PCG_INT_STATUS_OFF, 32'h0000_0001);
    wr(PCG_INT_STATUS_OFF, 32'h0000_0001);
    wr(PCG_INT_MASK_OFF, '0);
    probe(PCG_PWM_BIT, 1'b1);
    settle();
    chk(irq_out, 1'b0);
    wr(PCG_INT_MASK_OFF, 32'h0000_0001);
    settle();
    chk(irq_out, 1'b1);
    wr(PCG_INT_STATUS_OFF, 32'h0000_0001);
    settle();
    chk(irq_out, 1'b0);
    // second reset in mid-run
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    rd(PCG_SLEEP_ZERO_OFF, '0);
    close_out();
  end
endmodule
